// ### ial_pkg.sv
// constants, operation codes and carrier types of the integer alu datapath
// How it works
// - plain add sums low 16 bits
// - suffix runs op only on matching carry
// - 16-bit add of unsigned seven-bit immediate
// - wide add gives full 24-bit sum
// - wide add may target stack pointer
// - add with carry adds carry flag
// - plain subtract: destination minus source, 16 bits
// - wide subtract gives 24-bit difference
// - wide subtract may decrease stack pointer
// - subtract with borrow uses carry flag
// - 16-bit compare, signed immediate, sets flags
// - wide compare over 24 bits sets flags
// - compare with carry includes carry flag
// - bitwise and into destination
// - bitwise or into destination
// - exclusive or into destination
// - inversion writes ones complement
// - wide load copies into stack pointer
// - stack store writes zero-extended 32-bit word
// - stack store post-inc, post-dec, pre-dec
`default_nettype none

package ial_pkg;

	localparam int IAL_W     = 24;
	localparam int IAL_NW    = 16;
	localparam int IAL_IMM_W = 7;
	localparam int IAL_MEM_W = 32;
	localparam int IAL_IDX_W = 3;

	// the upper byte that narrow results and stack words are padded with
	localparam logic [7:0]  IAL_PAD8       = 8'h00;
	localparam logic [23:0] IAL_STACK_STEP = 24'h000004;
	localparam logic [23:0] IAL_SP_RST     = 24'h000000;

	typedef enum logic [3:0] {
		IAL_OP_ADD  = 4'h0,
		IAL_OP_ADC  = 4'h1,
		IAL_OP_SUB  = 4'h2,
		IAL_OP_SBC  = 4'h3,
		IAL_OP_ADDA = 4'h4,
		IAL_OP_SUBA = 4'h5,
		IAL_OP_CMP  = 4'h6,
		IAL_OP_CMPA = 4'h7,
		IAL_OP_CMC  = 4'h8,
		IAL_OP_AND  = 4'h9,
		IAL_OP_OR   = 4'hA,
		IAL_OP_XOR  = 4'hB,
		IAL_OP_NOT  = 4'hC,
		IAL_OP_LDSP = 4'hD,
		IAL_OP_STSP = 4'hE
	} ial_op_t;

	typedef enum logic [1:0] {
		IAL_CND_ALWAYS = 2'h0,
		IAL_CND_C      = 2'h1,
		IAL_CND_NC     = 2'h2
	} ial_cond_t;

	typedef enum logic [1:0] {
		IAL_STK_PLAIN   = 2'h0,
		IAL_STK_POSTINC = 2'h1,
		IAL_STK_POSTDEC = 2'h2,
		IAL_STK_PREDEC  = 2'h3
	} ial_stk_t;

	typedef struct packed {
		logic c;
		logic v;
		logic z;
		logic n;
	} ial_flags_t;

	typedef struct packed {
		logic                 valid;
		ial_op_t              op;
		ial_cond_t            cond;
		logic                 imm_sel;
		logic                 sp_dst;
		ial_stk_t             stk;
		logic [IAL_IDX_W-1:0] dst_idx;
		logic [IAL_IMM_W-1:0] imm;
		logic [IAL_W-1:0]     rd_val;
		logic [IAL_W-1:0]     rs_val;
	} ial_req_t;

	typedef struct packed {
		logic                 done;
		logic                 skipped;
		logic                 wb_en;
		logic [IAL_IDX_W-1:0] wb_idx;
		logic [IAL_W-1:0]     wb_data;
		logic [IAL_W-1:0]     sp;
		ial_flags_t           flags;
		logic                 mem_we;
		logic [IAL_W-1:0]     mem_addr;
		logic [IAL_MEM_W-1:0] mem_wdata;
	} ial_state_t;

	localparam ial_state_t IAL_STATE_RST = '{
		done: 1'b0, skipped: 1'b0, wb_en: 1'b0, wb_idx: 3'h0,
		wb_data: 24'h000000, sp: IAL_SP_RST, flags: 4'h0,
		mem_we: 1'b0, mem_addr: 24'h000000, mem_wdata: 32'h00000000
	};

endpackage : ial_pkg

`default_nettype wire

// ### ial_addsub.sv
// shared adder and subtractor with flag generation for 16 and 24 bits
`default_nettype none

module ial_addsub
	import ial_pkg::*;
(
	input  wire logic [IAL_W-1:0] a,
	input  wire logic [IAL_W-1:0] b,
	input  wire logic             cin,
	input  wire logic             sub,
	input  wire logic             wide,
	output logic [IAL_W-1:0]      sum,
	output ial_flags_t            flags
);

	logic [IAL_W-1:0]  bx;
	logic              cx;
	logic [IAL_W:0]    s24;
	logic [IAL_NW:0]   s16;
	logic              cout;
	logic              am;
	logic              bm;
	logic              rm;

	// subtract as a plus not b; cin is a borrow then, so it is inverted
	always_comb begin
		bx  = sub ? ~b : b;
		cx  = sub ? ~cin : cin;
		s24 = {1'b0, a} + {1'b0, bx} + {24'h000000, cx};
		s16 = {1'b0, a[IAL_NW-1:0]} + {1'b0, bx[IAL_NW-1:0]}
			+ {16'h0000, cx};
	end

	// narrow results leave the upper byte clear
	always_comb begin
		if (wide) begin
			sum  = s24[IAL_W-1:0];
			cout = s24[IAL_W];
			am   = a[IAL_W-1];
			bm   = bx[IAL_W-1];
			rm   = s24[IAL_W-1];
		end else begin
			sum  = {IAL_PAD8, s16[IAL_NW-1:0]};
			cout = s16[IAL_NW];
			am   = a[IAL_NW-1];
			bm   = bx[IAL_NW-1];
			rm   = s16[IAL_NW-1];
		end
	end

	// carry reads as borrow after a subtraction
	always_comb begin
		flags.c = sub ? ~cout : cout;
		flags.v = (am == bm) && (rm != am);
		flags.n = rm;
		flags.z = wide ? (s24[IAL_W-1:0] == 24'h000000)
			: (s16[IAL_NW-1:0] == 16'h0000);
	end

endmodule : ial_addsub

`default_nettype wire

// ### ial_core.sv
// integer arithmetic, compare, logic and stack pointer datapath
`default_nettype none

module ial_core
	import ial_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire ial_req_t         req,
	output logic                  done,
	output logic                  skipped,
	output logic                  wb_en,
	output logic [IAL_IDX_W-1:0]  wb_idx,
	output logic [IAL_W-1:0]      wb_data,
	output logic [IAL_W-1:0]      sp,
	output ial_flags_t            flags,
	output logic                  mem_we,
	output logic [IAL_W-1:0]      mem_addr,
	output logic [IAL_MEM_W-1:0]  mem_wdata
);

	ial_state_t        s_q;
	ial_state_t        s_d;
	logic              exec;
	logic              imm_signed;
	logic [IAL_W-1:0]  imm_u;
	logic [IAL_W-1:0]  imm_s;
	logic [IAL_W-1:0]  opa;
	logic [IAL_W-1:0]  opb;
	logic              as_sub;
	logic              as_wide;
	logic              as_cin;
	logic [IAL_W-1:0]  as_sum;
	ial_flags_t        as_flags;
	logic [IAL_NW-1:0] lg_res;
	logic [IAL_W-1:0]  st_addr;
	logic [IAL_W-1:0]  sp_after;

	// carry suffix gate; the flag is the one left by the previous op
	always_comb begin
		case (req.cond)
			IAL_CND_ALWAYS: exec = 1'b1;
			IAL_CND_C:      exec = s_q.flags.c;
			IAL_CND_NC:     exec = ~s_q.flags.c;
			default:        exec = 1'b0;
		endcase
	end

	// compare, compare with carry and logic ops take a signed immediate, the rest (wide compare too) unsigned
	always_comb begin
		case (req.op)
			IAL_OP_CMP, IAL_OP_CMC, IAL_OP_AND,
			IAL_OP_OR, IAL_OP_XOR, IAL_OP_NOT: imm_signed = 1'b1;
			default:                           imm_signed = 1'b0;
		endcase
	end

	// operand selection
	always_comb begin
		imm_u = {17'h00000, req.imm};
		imm_s = {{17{req.imm[IAL_IMM_W-1]}}, req.imm};
		if (req.imm_sel) begin
			opb = imm_signed ? imm_s : imm_u;
		end else begin
			opb = req.rs_val;
		end
		opa = req.sp_dst ? s_q.sp : req.rd_val;
	end

	// adder steering: direction, width and whether carry joins in
	always_comb begin
		as_sub  = 1'b0;
		as_wide = 1'b0;
		as_cin  = 1'b0;
		case (req.op)
			IAL_OP_ADC: as_cin = s_q.flags.c;
			IAL_OP_SUB, IAL_OP_CMP: as_sub = 1'b1;
			IAL_OP_SBC, IAL_OP_CMC: begin
				as_sub = 1'b1;
				as_cin = s_q.flags.c;
			end
			IAL_OP_ADDA: as_wide = 1'b1;
			IAL_OP_SUBA, IAL_OP_CMPA: begin
				as_sub  = 1'b1;
				as_wide = 1'b1;
			end
			default: as_sub = 1'b0;
		endcase
	end

	ial_addsub u_addsub (
		.a     (opa),
		.b     (opb),
		.cin   (as_cin),
		.sub   (as_sub),
		.wide  (as_wide),
		.sum   (as_sum),
		.flags (as_flags)
	);

	// bitwise unit works on the 16-bit data part only
	always_comb begin
		case (req.op)
			IAL_OP_AND: lg_res = opa[IAL_NW-1:0] & opb[IAL_NW-1:0];
			IAL_OP_OR:  lg_res = opa[IAL_NW-1:0] | opb[IAL_NW-1:0];
			IAL_OP_XOR: lg_res = opa[IAL_NW-1:0] ^ opb[IAL_NW-1:0];
			IAL_OP_NOT: lg_res = ~opb[IAL_NW-1:0];
			default:    lg_res = 16'h0000;
		endcase
	end

	// stack address and pointer after the access
	always_comb begin
		st_addr  = s_q.sp;
		sp_after = s_q.sp;
		case (req.stk)
			IAL_STK_POSTINC: sp_after = s_q.sp + IAL_STACK_STEP;
			IAL_STK_POSTDEC: sp_after = s_q.sp - IAL_STACK_STEP;
			IAL_STK_PREDEC: begin
				st_addr  = s_q.sp - IAL_STACK_STEP;
				sp_after = st_addr;
			end
			default: sp_after = s_q.sp;
		endcase
	end

	// next state; strobes fall back to zero so each result is one pulse
	always_comb begin
		s_d         = s_q;
		s_d.done    = 1'b0;
		s_d.skipped = 1'b0;
		s_d.wb_en   = 1'b0;
		s_d.mem_we  = 1'b0;
		if (req.valid) begin
			s_d.done   = 1'b1;
			s_d.wb_idx = req.dst_idx;
			if (!exec) begin
				// a skipped op leaves only the done and skipped pulses and the new wb_idx
				s_d.skipped = 1'b1;
			end else begin
				case (req.op)
					IAL_OP_ADD, IAL_OP_ADC, IAL_OP_SUB, IAL_OP_SBC: begin
						s_d.wb_en   = 1'b1;
						s_d.wb_data = as_sum;
						s_d.flags   = as_flags;
					end
					IAL_OP_ADDA, IAL_OP_SUBA: begin
						if (req.sp_dst) begin
							// pointer arithmetic leaves the flags alone
							s_d.sp = as_sum;
						end else begin
							s_d.wb_en   = 1'b1;
							s_d.wb_data = as_sum;
							s_d.flags   = as_flags;
						end
					end
					IAL_OP_CMP, IAL_OP_CMPA, IAL_OP_CMC: begin
						s_d.flags = as_flags;
					end
					IAL_OP_AND, IAL_OP_OR, IAL_OP_XOR, IAL_OP_NOT: begin
						s_d.wb_en   = 1'b1;
						s_d.wb_data = {IAL_PAD8, lg_res};
						s_d.flags.n = lg_res[IAL_NW-1];
						s_d.flags.z = (lg_res == 16'h0000);
						s_d.flags.v = 1'b0;
					end
					IAL_OP_LDSP: s_d.sp = opb;
					IAL_OP_STSP: begin
						s_d.mem_we    = 1'b1;
						s_d.mem_addr  = st_addr;
						s_d.mem_wdata = {IAL_PAD8, req.rs_val};
						s_d.sp        = sp_after;
					end
					default: s_d.skipped = 1'b1;
				endcase
			end
		end
	end

	// single state register; synchronous reset
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= IAL_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// every output is a field of the state register
	assign done      = s_q.done;
	assign skipped   = s_q.skipped;
	assign wb_en     = s_q.wb_en;
	assign wb_idx    = s_q.wb_idx;
	assign wb_data   = s_q.wb_data;
	assign sp        = s_q.sp;
	assign flags     = s_q.flags;
	assign mem_we    = s_q.mem_we;
	assign mem_addr  = s_q.mem_addr;
	assign mem_wdata = s_q.mem_wdata;

	// reference values seen only by the checks below
	logic [IAL_NW-1:0] chk_add16;
	logic [IAL_NW-1:0] chk_adc16;
	logic [IAL_NW-1:0] chk_sub16;
	logic [IAL_W-1:0]  chk_spadd;
	logic [IAL_W-1:0]  chk_spsub;
	logic [IAL_W-1:0]  chk_predec;
	logic [IAL_W-1:0]  chk_ldsp;
	logic [IAL_W-1:0]  chk_rs;

	always_comb begin
		chk_add16  = req.rd_val[IAL_NW-1:0] + req.rs_val[IAL_NW-1:0];
		chk_adc16  = chk_add16 + {15'h0000, s_q.flags.c};
		chk_sub16  = req.rd_val[IAL_NW-1:0] - req.rs_val[IAL_NW-1:0];
		chk_spadd  = s_q.sp + req.rs_val;
		chk_spsub  = s_q.sp - {17'h00000, req.imm};
		chk_predec = s_q.sp - IAL_STACK_STEP;
		chk_ldsp   = req.imm_sel ? {17'h00000, req.imm} : req.rs_val;
		chk_rs     = req.rs_val;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence run_op(ial_op_t o);
		req.valid && exec && req.op == o;
	endsequence

	sequence skip_op;
		req.valid && !exec;
	endsequence

	sequence stack_predec;
		req.valid && exec && req.op == IAL_OP_STSP
			&& req.stk == IAL_STK_PREDEC;
	endsequence

	done_pulse_a: assert property (
		req.valid |=> done ##1 (!done || $past(req.valid)))
		else $error("done is not a single pulse per request");

	skip_quiet_a: assert property (
		skip_op |=> skipped && !wb_en && !mem_we
			&& flags == $past(flags) && sp == $past(sp))
		else $error("skipped operation changed state");

	cond_run_a: assert property (
		req.valid && (req.op == IAL_OP_ADD || req.op == IAL_OP_SUB)
			&& ((req.cond == IAL_CND_C && s_q.flags.c)
			|| (req.cond == IAL_CND_NC && !s_q.flags.c))
			|=> wb_en && !skipped)
		else $error("carry suffix op did not run when due");

	add_sum_a: assert property (
		run_op(IAL_OP_ADD) and !req.imm_sel
			|=> wb_data == {IAL_PAD8, $past(chk_add16)})
		else $error("16-bit add result wrong");

	adc_sum_a: assert property (
		run_op(IAL_OP_ADC) and !req.imm_sel
			|=> wb_data[IAL_NW-1:0] == $past(chk_adc16))
		else $error("add with carry result wrong");

	sub_diff_a: assert property (
		run_op(IAL_OP_SUB) and !req.imm_sel
			|=> wb_data[IAL_NW-1:0] == $past(chk_sub16))
		else $error("16-bit subtract result wrong");

	cmp_no_wb_a: assert property (
		run_op(IAL_OP_CMP) or run_op(IAL_OP_CMPA) or run_op(IAL_OP_CMC)
			|=> !wb_en && wb_data == $past(wb_data))
		else $error("compare wrote the destination");

	sp_add_a: assert property (
		run_op(IAL_OP_ADDA) and req.sp_dst and !req.imm_sel
			|=> sp == $past(chk_spadd) && !wb_en)
		else $error("stack pointer add wrong");

	sp_sub_a: assert property (
		run_op(IAL_OP_SUBA) and req.sp_dst and req.imm_sel
			|=> sp == $past(chk_spsub))
		else $error("stack pointer subtract wrong");

	sp_load_a: assert property (
		run_op(IAL_OP_LDSP) |=> sp == $past(chk_ldsp))
		else $error("stack pointer load wrong");

	stack_word_a: assert property (
		run_op(IAL_OP_STSP) |=> mem_we
			&& mem_wdata == {IAL_PAD8, $past(chk_rs)})
		else $error("stack word not zero-extended register");

	predec_addr_a: assert property (
		stack_predec |=> mem_addr == $past(chk_predec)
			&& sp == mem_addr)
		else $error("pre-decrement store address wrong");

endmodule : ial_core

`default_nettype wire

// ### ial_rf_model.sv
// register file model on the decoder side of the alu datapath
`default_nettype none

module ial_rf_model
	import ial_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             wb_en,
	input  wire logic [2:0]       wb_idx,
	input  wire logic [IAL_W-1:0] wb_data,
	input  wire logic             ld_en,
	input  wire logic [2:0]       ld_idx,
	input  wire logic [IAL_W-1:0] ld_data,
	input  wire logic [2:0]       rd_idx,
	input  wire logic [2:0]       rs_idx,
	output logic [IAL_W-1:0]      rd_val,
	output logic [IAL_W-1:0]      rs_val
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [IAL_W-1:0] regs_q [8];

	// a preload wins; the bench never overlaps it with a result
	always_ff @(posedge clk) begin
		if (rst) begin
			regs_q <= '{default: 24'h000000};
		end else if (ld_en) begin
			regs_q[ld_idx] <= ld_data;
		end else if (wb_en) begin
			regs_q[wb_idx] <= wb_data;
		end
	end

	// operands read straight from storage
	assign rd_val = regs_q[rd_idx];
	assign rs_val = regs_q[rs_idx];

endmodule : ial_rf_model

`default_nettype wire

// ### cpu_integer_logic_alu_ops_bench.sv
// self-checking bench for the integer alu datapath
`default_nettype none

module cpu_integer_logic_alu_ops_bench
	import ial_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	ial_req_t             cmd = '0;
	ial_req_t             req;
	logic [2:0]           rs_idx = 3'h0;
	logic                 ld_en = 1'b0;
	logic [2:0]           ld_idx = 3'h0;
	logic [IAL_W-1:0]     ld_data = 24'h000000;
	logic [IAL_W-1:0]     rd_v, rs_v, wb_data, sp, mem_addr;
	logic                 done, skipped, wb_en, mem_we;
	logic [2:0]           wb_idx;
	logic [IAL_MEM_W-1:0] mem_wdata;
	ial_flags_t           flags;
	int                   error_cnt = 0;
	int                   samples_checked = 0;
	int                   cyc = 0;

	always #25 clk = ~clk;

	// operand values come from the register file model
	always_comb begin
		req = cmd;
		req.rd_val = rd_v;
		req.rs_val = rs_v;
	end

	ial_core uut (.clk(clk), .rst(rst), .req(req), .done(done),
		.skipped(skipped), .wb_en(wb_en), .wb_idx(wb_idx),
		.wb_data(wb_data), .sp(sp), .flags(flags), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata));

	ial_rf_model rf (.clk(clk), .rst(rst), .wb_en(wb_en), .wb_idx(wb_idx),
		.wb_data(wb_data), .ld_en(ld_en), .ld_idx(ld_idx),
		.ld_data(ld_data), .rd_idx(cmd.dst_idx), .rs_idx(rs_idx),
		.rd_val(rd_v), .rs_val(rs_v));

	task complete_run();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	// the whole run needs about a hundred cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			complete_run();
		end
	end

	task chk(input string w, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", w, e, s);
		end
	endtask : chk

	task setr(input logic [2:0] i, input logic [23:0] v);
		@(posedge clk);
		ld_en <= 1'b1;
		ld_idx <= i;
		ld_data <= v;
		@(posedge clk);
		ld_en <= 1'b0;
	endtask : setr

	// one request; its answer stands for one cycle after the next edge
	task run(input ial_op_t op, input ial_cond_t cd, input logic is,
		input logic sd, input ial_stk_t k, input logic [2:0] d,
		input logic [2:0] s, input logic [6:0] m);
		@(posedge clk);
		cmd <= '{1'b1, op, cd, is, sd, k, d, m, 24'h000000, 24'h000000};
		rs_idx <= s;
		@(posedge clk);
		cmd.valid <= 1'b0;
		#1;
		chk("done", 32'(done), 32'h1);
		chk("wb_idx", 32'(wb_idx), 32'(d));
	endtask : run

	task cnd(input ial_op_t op, input ial_cond_t cd, input logic [2:0] d);
		run(op, cd, 1'b0, 1'b0, IAL_STK_PLAIN, d, d, 7'h00);
	endtask : cnd

	task rr(input ial_op_t op, input logic [2:0] d, input logic [2:0] s);
		run(op, IAL_CND_ALWAYS, 1'b0, 1'b0, IAL_STK_PLAIN, d, s, 7'h00);
	endtask : rr

	task ri(input ial_op_t op, input logic [2:0] d, input logic [6:0] m);
		run(op, IAL_CND_ALWAYS, 1'b1, 1'b0, IAL_STK_PLAIN, d, 3'h0, m);
	endtask : ri

	task spo(input ial_op_t op, input logic is, input logic [2:0] s,
		input logic [6:0] m, input logic [23:0] e);
		run(op, IAL_CND_ALWAYS, is, 1'b1, IAL_STK_PLAIN, 3'h0, s, m);
		chk("sp", 32'(sp), 32'(e));
	endtask : spo

	task wb(input logic [23:0] e);
		chk("wb_en", 32'(wb_en), 32'h1);
		chk("wb_data", 32'(wb_data), 32'(e));
	endtask : wb

	task cz(input logic c, input logic z);
		chk("carry", 32'(flags.c), 32'(c));
		chk("zero", 32'(flags.z), 32'(z));
	endtask : cz

	task st(input ial_stk_t k, input logic [23:0] a, input logic [23:0] e);
		run(IAL_OP_STSP, IAL_CND_ALWAYS, 1'b0, 1'b0, k, 3'h0, 3'h3, 7'h00);
		chk("mem_we", 32'(mem_we), 32'h1);
		chk("mem_addr", 32'(mem_addr), 32'(a));
		chk("mem_wdata", mem_wdata, 32'h00923456);
		chk("sp", 32'(sp), 32'(e));
	endtask : st

	// narrow results wrap at 16 bits and clear the upper byte
	task t_arith();
		setr(3'h1, 24'h01FFFF);
		setr(3'h2, 24'h000001);
		rr(IAL_OP_ADD, 3'h1, 3'h2);
		wb(24'h000000);
		cz(1'b1, 1'b1);
		setr(3'h3, 24'h000010);
		rr(IAL_OP_ADC, 3'h3, 3'h2);
		wb(24'h000012);
		ri(IAL_OP_ADD, 3'h3, 7'h7F);
		wb(24'h000091);
		rr(IAL_OP_SUB, 3'h3, 3'h2);
		wb(24'h000090);
		ri(IAL_OP_SUB, 3'h2, 7'h02);
		wb(24'h00FFFF);
		cz(1'b1, 1'b0);
		chk("negative", 32'(flags.n), 32'h1);
		chk("overflow", 32'(flags.v), 32'h0);
		rr(IAL_OP_SBC, 3'h3, 3'h2);
		wb(24'h000090);
		// crossing into the sign bit must raise overflow
		setr(3'h6, 24'h007FFF);
		ri(IAL_OP_ADD, 3'h6, 7'h01);
		wb(24'h008000);
		chk("overflow", 32'(flags.v), 32'h1);
		chk("negative", 32'(flags.n), 32'h1);
		$display("test arith done");
	endtask : t_arith

	task t_wide();
		setr(3'h4, 24'h00FFFF);
		setr(3'h5, 24'h000001);
		rr(IAL_OP_ADDA, 3'h4, 3'h5);
		wb(24'h010000);
		ri(IAL_OP_ADDA, 3'h4, 7'h7F);
		wb(24'h01007F);
		ri(IAL_OP_SUBA, 3'h4, 7'h7F);
		wb(24'h010000);
		rr(IAL_OP_SUBA, 3'h4, 3'h5);
		wb(24'h00FFFF);
		spo(IAL_OP_LDSP, 1'b1, 3'h0, 7'h40, 24'h000040);
		spo(IAL_OP_ADDA, 1'b1, 3'h0, 7'h10, 24'h000050);
		spo(IAL_OP_ADDA, 1'b0, 3'h4, 7'h00, 24'h01004F);
		spo(IAL_OP_SUBA, 1'b0, 3'h5, 7'h00, 24'h01004E);
		spo(IAL_OP_SUBA, 1'b1, 3'h0, 7'h0E, 24'h010040);
		spo(IAL_OP_LDSP, 1'b0, 3'h4, 7'h00, 24'h00FFFF);
		$display("test wide done");
	endtask : t_wide

	// the immediates chosen tell signed from unsigned extension apart
	task t_cmp();
		setr(3'h1, 24'h00FFFF);
		ri(IAL_OP_CMP, 3'h1, 7'h7F);
		cz(1'b0, 1'b1);
		chk("wb_en", 32'(wb_en), 32'h0);
		setr(3'h6, 24'h010000);
		rr(IAL_OP_CMPA, 3'h6, 3'h0);
		cz(1'b0, 1'b0);
		setr(3'h7, 24'h00007F);
		ri(IAL_OP_CMPA, 3'h7, 7'h7F);
		cz(1'b0, 1'b1);
		rr(IAL_OP_CMP, 3'h0, 3'h5);
		cz(1'b1, 1'b0);
		rr(IAL_OP_CMC, 3'h5, 3'h0);
		cz(1'b0, 1'b1);
		chk("wb_en", 32'(wb_en), 32'h0);
		$display("test cmp done");
	endtask : t_cmp

	task t_logic();
		setr(3'h1, 24'h001234);
		ri(IAL_OP_AND, 3'h1, 7'h40);
		wb(24'h001200);
		ri(IAL_OP_OR, 3'h1, 7'h05);
		wb(24'h001205);
		rr(IAL_OP_XOR, 3'h1, 3'h4);
		wb(24'h00EDFA);
		chk("negative", 32'(flags.n), 32'h1);
		ri(IAL_OP_NOT, 3'h1, 7'h01);
		wb(24'h00FFFE);
		rr(IAL_OP_NOT, 3'h1, 3'h6);
		wb(24'h00FFFF);
		$display("test logic done");
	endtask : t_logic

	task t_cond();
		rr(IAL_OP_CMP, 3'h0, 3'h0);
		cnd(IAL_OP_ADD, IAL_CND_C, 3'h5);
		chk("skipped", 32'(skipped), 32'h1);
		chk("wb_en", 32'(wb_en), 32'h0);
		cz(1'b0, 1'b1);
		cnd(IAL_OP_ADD, IAL_CND_NC, 3'h5);
		wb(24'h000002);
		rr(IAL_OP_CMP, 3'h0, 3'h5);
		run(IAL_OP_ADDA, IAL_CND_NC, 1'b1, 1'b1, IAL_STK_PLAIN, 3'h0,
			3'h0, 7'h01);
		chk("skipped", 32'(skipped), 32'h1);
		chk("sp", 32'(sp), 32'h0000FFFF);
		cnd(IAL_OP_SUB, IAL_CND_C, 3'h5);
		wb(24'h000000);
		chk("skipped", 32'(skipped), 32'h0);
		$display("test cond done");
	endtask : t_cond

	task t_stack();
		spo(IAL_OP_LDSP, 1'b1, 3'h0, 7'h40, 24'h000040);
		setr(3'h3, 24'h923456);
		st(IAL_STK_PREDEC, 24'h00003C, 24'h00003C);
		st(IAL_STK_POSTINC, 24'h00003C, 24'h000040);
		st(IAL_STK_POSTDEC, 24'h000040, 24'h00003C);
		st(IAL_STK_PLAIN, 24'h00003C, 24'h00003C);
		$display("test stack done");
	endtask : t_stack

	// tests share register contents, so their order matters
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_arith();
		t_wide();
		t_cmp();
		t_logic();
		t_cond();
		t_stack();
		complete_run();
	end

endmodule : cpu_integer_logic_alu_ops_bench

`default_nettype wire
